// ==== hw/csem_socket_event.sv ====
// Contract
// - socket block decodes flags 00h, enables 04h, state 08h, force 0Ch; control 10h and pm 20h are not decoded and read zero
// - each socket has its own base address register at config offset 10h
// - flags record only that a status changed, not its new value
// - writing one clears an event flag, writing zero leaves it
// - writing one to a force-event bit sets that event flag
// - reset clears flags; after card reset a still-present condition sets again
// - bits 31 to 4 of flags and enables read zero
// - flag 3 sets on any power-cycle state change and stays until cleared
// - flag 2 sets on any second card-detect change
// - flag 1 sets on any first card-detect change
// - cardbus card: flag 0 sets on rising card status-change edge only
// - 16-bit card: flag 0 sets on both status-change edges
// - enables gate only the interrupt; flags set regardless
// - enable bit 3 gates the power-cycle event, reset 0
// - enable bits 2-1 gate detect events; 11 enables, 00 reset
// - enable bit 0 gates the card status event, reset 0
`timescale 1ns/1ps
`default_nettype none
module csem_socket_event
   import csem_pkg::*;
(
   input  wire logic                     i_sys_clk,
   input  wire logic                     i_sys_rst,
   // configuration space access
   input  wire logic                     i_cfg_wr,
   input  wire logic                     i_cfg_rd,
   input  wire logic [CFG_ADDR_BITS-1:0] i_cfg_addr,
   input  wire logic [DATA_BITS-1:0]     i_cfg_wdata,
   input  wire logic [3:0]               i_cfg_be,
   output logic      [DATA_BITS-1:0]     o_cfg_rdata,
   output logic                          o_cfg_rvalid,
   // memory space access
   input  wire logic                     i_mem_wr,
   input  wire logic                     i_mem_rd,
   input  wire logic [ADDR_BITS-1:0]     i_mem_addr,
   input  wire logic [DATA_BITS-1:0]     i_mem_wdata,
   input  wire logic [3:0]               i_mem_be,
   output logic      [DATA_BITS-1:0]     o_mem_rdata,
   output logic                          o_mem_rvalid,
   output logic                          o_mem_hit,
   // socket status inputs
   input  wire logic                     i_power_cycle_state,
   input  wire logic                     i_detect_one_state,
   input  wire logic                     i_detect_two_state,
   input  wire logic                     i_card_change_state,
   input  wire logic                     i_cardbus_card,
   input  wire logic                     i_card_reset,
   output logic                          o_status_change_interrupt
);
   typedef struct packed {
      logic [ADDR_BITS-1:WINDOW_BITS] base;
      logic [EVENT_BITS-1:0]          flags;
      logic [EVENT_BITS-1:0]          enables;
      logic [DATA_BITS-1:0]           mem_rdata;
      logic                           mem_rvalid;
      logic                           mem_hit;
      logic [DATA_BITS-1:0]           cfg_rdata;
      logic                           cfg_rvalid;
      logic                           irq;
   } csem_regs_type;

   csem_regs_type r;
   csem_regs_type next_r;

   logic [EVENT_BITS-1:0] raw_state;
   logic                  hit;
   logic [11:0]           ofs;
   logic                  wr_lo;
   logic [EVENT_BITS-1:0] wr_bits;
   logic [EVENT_BITS-1:0] clr_bits;
   logic [EVENT_BITS-1:0] force_bits;
   logic [EVENT_BITS-1:0] gate;
   logic [DATA_BITS-1:0]  rd_word;

   csem_change_if chg ();

   always_comb begin
      raw_state              = '0;
      raw_state[BIT_CARD]    = i_card_change_state;
      raw_state[BIT_DETECT1] = i_detect_one_state;
      raw_state[BIT_DETECT2] = i_detect_two_state;
      raw_state[BIT_POWER]   = i_power_cycle_state;
   end

   csem_change_detect u_detect (
      .i_sys_clk      (i_sys_clk),
      .i_sys_rst      (i_sys_rst),
      .i_state        (raw_state),
      .i_cardbus_card (i_cardbus_card),
      .i_card_reset   (i_card_reset),
      .chg            (chg.detector)
   );

   // window decode against this socket's own base
   assign hit   = (i_mem_addr[ADDR_BITS-1:WINDOW_BITS] == r.base);
   assign ofs   = i_mem_addr[WINDOW_BITS-1:0];
   // implemented bits all live in byte lane 0
   assign wr_lo = i_mem_wr & hit & i_mem_be[0];
   assign wr_bits = i_mem_wdata[EVENT_BITS-1:0];

   always_comb begin
      clr_bits   = '0;
      force_bits = '0;
      if (wr_lo && (ofs == OFS_FLAGS)) begin
         clr_bits = wr_bits;
      end
      if (wr_lo && (ofs == OFS_FORCE)) begin
         force_bits = wr_bits;
      end
   end

   // reserved enable patterns 01/10 are treated as off, only 11 reaches the interrupt
   always_comb begin
      gate              = '0;
      gate[BIT_POWER]   = r.enables[BIT_POWER];
      gate[BIT_DETECT1] = r.enables[BIT_DETECT1] & r.enables[BIT_DETECT2];
      gate[BIT_DETECT2] = r.enables[BIT_DETECT1] & r.enables[BIT_DETECT2];
      gate[BIT_CARD]    = r.enables[BIT_CARD];
   end

   always_comb begin
      rd_word = READ_ZERO;
      if (ofs == OFS_FLAGS) begin
         rd_word[EVENT_BITS-1:0] = r.flags;
      end else if (ofs == OFS_ENABLES) begin
         rd_word[EVENT_BITS-1:0] = r.enables;
      end else if (ofs == OFS_PRESENT) begin
         rd_word[EVENT_BITS-1:0] = chg.state;
      end else begin
         // force is write-only; control, reserved, power management and the rest read zero
         rd_word = READ_ZERO;
      end
   end

   always_comb begin
      next_r = r;

      // set wins over a clear in the same cycle, and enables never block the set
      next_r.flags = (r.flags & ~clr_bits) | chg.change | force_bits;

      if (wr_lo && (ofs == OFS_ENABLES)) begin
         next_r.enables = wr_bits;
      end

      if (i_cfg_wr && (i_cfg_addr == CFG_OFS_BASE)) begin
         if (i_cfg_be[1]) begin
            next_r.base[15:WINDOW_BITS] = i_cfg_wdata[15:WINDOW_BITS];
         end
         if (i_cfg_be[2]) begin
            next_r.base[23:16] = i_cfg_wdata[23:16];
         end
         if (i_cfg_be[3]) begin
            next_r.base[31:24] = i_cfg_wdata[31:24];
         end
      end

      next_r.cfg_rvalid = i_cfg_rd;
      next_r.cfg_rdata  = READ_ZERO;
      if (i_cfg_rd && (i_cfg_addr == CFG_OFS_BASE)) begin
         next_r.cfg_rdata[ADDR_BITS-1:WINDOW_BITS] = r.base;
      end

      next_r.mem_hit    = (i_mem_rd | i_mem_wr) & hit;
      next_r.mem_rvalid = i_mem_rd & hit;
      next_r.mem_rdata  = (i_mem_rd && hit) ? rd_word : READ_ZERO;

      // software must clear stale flags before unmasking or this fires at once
      next_r.irq = |(r.flags & gate);
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         r         <= '0;
         r.flags   <= FLAGS_RESET;
         r.enables <= ENABLES_RESET;
         r.base    <= BASE_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign o_cfg_rdata               = r.cfg_rdata;
   assign o_cfg_rvalid              = r.cfg_rvalid;
   assign o_mem_rdata               = r.mem_rdata;
   assign o_mem_rvalid              = r.mem_rvalid;
   assign o_mem_hit                 = r.mem_hit;
   assign o_status_change_interrupt = r.irq;
endmodule : csem_socket_event
`default_nettype wire

// ==== shared/csem_pkg.sv ====
`default_nettype none
package csem_pkg;
   localparam int          EVENT_BITS      = 4;
   localparam int          WINDOW_BITS     = 12;
   localparam int          ADDR_BITS       = 32;
   localparam int          DATA_BITS       = 32;
   localparam int          CFG_ADDR_BITS   = 8;

   // socket register block, byte offsets within the window
   localparam logic [11:0] OFS_FLAGS       = 12'h000;
   localparam logic [11:0] OFS_ENABLES     = 12'h004;
   localparam logic [11:0] OFS_PRESENT     = 12'h008;
   localparam logic [11:0] OFS_FORCE       = 12'h00c;
   localparam logic [11:0] OFS_CONTROL     = 12'h010;
   localparam logic [11:0] OFS_RSVD_LO     = 12'h014;
   localparam logic [11:0] OFS_RSVD_HI     = 12'h01c;
   localparam logic [11:0] OFS_POWER_MGMT  = 12'h020;

   // configuration space offset of the socket base address register
   localparam logic [7:0]  CFG_OFS_BASE    = 8'h10;

   // event / enable bit positions
   localparam int          BIT_CARD        = 0;
   localparam int          BIT_DETECT1     = 1;
   localparam int          BIT_DETECT2     = 2;
   localparam int          BIT_POWER       = 3;

   localparam logic [3:0]  FLAGS_RESET     = 4'h0;
   localparam logic [3:0]  ENABLES_RESET   = 4'h0;
   localparam logic [19:0] BASE_RESET      = 20'h00000;
   localparam logic [31:0] READ_ZERO       = 32'h00000000;
endpackage : csem_pkg
`default_nettype wire

// ==== shared/csem_change_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface csem_change_if;
   import csem_pkg::*;
   logic [EVENT_BITS-1:0] state;
   logic [EVENT_BITS-1:0] change;
   modport detector (output state, output change);
   modport consumer (input state, input change);
endinterface : csem_change_if
`default_nettype wire

// ==== hw/csem_change_detect.sv ====
`timescale 1ns/1ps
`default_nettype none
module csem_change_detect
   import csem_pkg::*;
(
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_sys_rst,
   input  wire logic [EVENT_BITS-1:0] i_state,
   input  wire logic                  i_cardbus_card,
   input  wire logic                  i_card_reset,
   csem_change_if.detector            chg
);
   typedef struct packed {
      logic [EVENT_BITS-1:0] prev;
   } csem_detect_type;

   csem_detect_type r;
   csem_detect_type next_r;

   // per-bit drivers land on a net, the interface variable then has one driver
   wire logic [EVENT_BITS-1:0] edge_seen;

   always_comb begin
      next_r      = r;
      next_r.prev = i_state;
      // held at the idle baseline in card reset so a still-present level is seen anew on release
      if (i_card_reset) begin
         next_r.prev = '0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign chg.state  = i_state;
   assign chg.change = edge_seen;

   // change only, never the new level
   genvar gi;
   generate
      for (gi = 0; gi < EVENT_BITS; gi++) begin : g_bit
         if (gi == BIT_CARD) begin : g_card
            assign edge_seen[gi] = i_card_reset ? 1'b0 :
                                   (i_cardbus_card ? (i_state[gi] & ~r.prev[gi])
                                                   : (i_state[gi] ^ r.prev[gi]));
         end else begin : g_level
            assign edge_seen[gi] = ~i_card_reset & (i_state[gi] ^ r.prev[gi]);
         end
      end
   endgenerate
endmodule : csem_change_detect
`default_nettype wire

// ==== dv/csem_socket_event_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module csem_socket_event_chk
   import csem_pkg::*;
(
   input wire logic        i_sys_clk,
   input wire logic        i_sys_rst,
   input wire logic        i_cfg_rd,
   input wire logic        i_mem_wr,
   input wire logic        i_mem_rd,
   input wire logic [31:0] i_mem_addr,
   input wire logic        i_power_cycle_state,
   input wire logic        i_detect_one_state,
   input wire logic        i_detect_two_state,
   input wire logic        i_card_change_state,
   input wire logic        i_cardbus_card,
   input wire logic        i_card_reset,
   input wire logic [31:0] o_cfg_rdata,
   input wire logic        o_cfg_rvalid,
   input wire logic [31:0] o_mem_rdata,
   input wire logic        o_mem_rvalid,
   input wire logic        o_mem_hit,
   input wire logic        o_status_change_interrupt
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   logic [3:0]  st;
   logic [11:0] ofs;
   logic [1:0]  up;
   assign st  = {i_power_cycle_state, i_detect_two_state, i_detect_one_state, i_card_change_state};
   assign ofs = i_mem_addr[11:0];
   // levels high across reset set flags right after release, so settle first
   always_ff @(posedge i_sys_clk) up <= i_sys_rst ? 2'h0 : (up == 2'h3 ? up : up + 2'h1);
   sequence quiet;
      !i_mem_wr && $stable({st, i_cardbus_card, i_card_reset});
   endsequence
   cfg_answer_a:
      assert property (o_cfg_rvalid == $past(i_cfg_rd)) else $error("config answer timing");
   base_low_zero_a:
      assert property (o_cfg_rdata[11:0] == 12'h000) else $error("base low bits not zero");
   read_answer_a:
      assert property (o_mem_rvalid |-> o_mem_hit && $past(i_mem_rd)) else $error("read answer without read");
   hit_cause_a:
      assert property (o_mem_hit |-> $past(i_mem_rd) || $past(i_mem_wr)) else $error("hit without access");
   idle_rdata_a:
      assert property (!o_mem_rvalid |-> o_mem_rdata == 32'h0) else $error("read data outside answer");
   upper_zero_a:
      assert property (o_mem_rvalid && $past(ofs) < 12'h00c |-> o_mem_rdata[31:4] == 28'h0)
         else $error("upper bits not zero");
   dead_offsets_a:
      assert property (o_mem_rvalid && $past(ofs) inside {12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c, 12'h020}
         |-> o_mem_rdata == 32'h0) else $error("unused offset not zero");
   present_read_a:
      assert property (o_mem_rvalid && $past(ofs) == 12'h008 |-> o_mem_rdata[3:0] == $past(st))
         else $error("present state mismatch");
   irq_steady_a:
      assert property ((up == 2'h3) ##0 quiet [*3] |-> $stable(o_status_change_interrupt))
         else $error("interrupt moved without cause");
endmodule // csem_socket_event_chk
bind csem_socket_event csem_socket_event_chk chk_u (.*);
`default_nettype wire

// ==== dv/csem_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module csem_host_model
   import csem_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic [31:0] i_cfg_rdata,
   input  wire logic [31:0] i_mem_rdata,
   output logic             o_cfg_wr,
   output logic             o_cfg_rd,
   output logic             o_mem_wr,
   output logic             o_mem_rd,
   output logic [31:0]      o_addr,
   output logic [31:0]      o_wdata
);
   // no wait states: strobe lasts one cycle, answer comes the cycle after
   task automatic acc(input logic cfg, input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(negedge i_sys_clk);
      o_cfg_wr = cfg & wr;
      o_cfg_rd = cfg & ~wr;
      o_mem_wr = ~cfg & wr;
      o_mem_rd = ~cfg & ~wr;
      o_addr   = a;
      o_wdata  = d;
      @(negedge i_sys_clk);
      {o_cfg_wr, o_cfg_rd, o_mem_wr, o_mem_rd} = 4'h0;
      q        = cfg ? i_cfg_rdata : i_mem_rdata;
      // released bus shows garbage, not the last value
      o_addr   = ~a;
      o_wdata  = ~d;
   endtask
   initial begin
      {o_cfg_wr, o_cfg_rd, o_mem_wr, o_mem_rd} = 4'h0;
      o_addr  = 32'h0;
      o_wdata = 32'h0;
   end
endmodule // csem_host_model
`default_nettype wire

// ==== dv/cardbus_socket_event_mask_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module cardbus_socket_event_mask_tb;
   import csem_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  st = 4'h0;
   logic        cb = 1'b1;
   logic        crst = 1'b0;
   logic        cwr, crd, mwr, mrd, crv, mrv, hit, irq;
   logic [31:0] addr, wdata, crdata, mrdata, q, base = 32'h0;
   logic [11:0] tab [6] = '{12'h0f0, 12'h881, 12'h220, 12'h621, 12'h111, 12'h870};
   int          n_fail = 0;
   int          check_count = 0;
   always #4 clk = ~clk;
   csem_host_model host_u (.i_sys_clk(clk), .i_cfg_rdata(crdata), .i_mem_rdata(mrdata), .o_cfg_wr(cwr),
      .o_cfg_rd(crd), .o_mem_wr(mwr), .o_mem_rd(mrd), .o_addr(addr), .o_wdata(wdata));
   csem_socket_event dut_u (.i_sys_clk(clk), .i_sys_rst(rst), .i_cfg_wr(cwr), .i_cfg_rd(crd),
      .i_cfg_addr(addr[7:0]), .i_cfg_wdata(wdata), .i_cfg_be(4'hf), .o_cfg_rdata(crdata), .o_cfg_rvalid(crv),
      .i_mem_wr(mwr), .i_mem_rd(mrd), .i_mem_addr(addr), .i_mem_wdata(wdata), .i_mem_be(4'hf),
      .o_mem_rdata(mrdata), .o_mem_rvalid(mrv), .o_mem_hit(hit), .i_power_cycle_state(st[3]),
      .i_detect_one_state(st[1]), .i_detect_two_state(st[2]), .i_card_change_state(st[0]),
      .i_cardbus_card(cb), .i_card_reset(crst), .o_status_change_interrupt(irq));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask
   task automatic rd(input logic [11:0] o, input logic [31:0] e);
      host_u.acc(1'b0, 1'b0, base | {20'h0, o}, 32'h0, q);
      chk($sformatf("rdata_%h", o), e, q);
   endtask
   task automatic wr(input logic [11:0] o, input logic [31:0] d);
      host_u.acc(1'b0, 1'b1, base | {20'h0, o}, d, q);
   endtask
   task automatic end_of_test();
      if (n_fail == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      rd(12'h000, 32'h0);
      rd(12'h004, 32'h0);
      host_u.acc(1'b1, 1'b1, 32'h10, 32'h0000_5abc, q);
      host_u.acc(1'b1, 1'b0, 32'h10, 32'h0, q);
      chk("cfg_base", 32'h0000_5000, q);
      host_u.acc(1'b0, 1'b0, 32'h0, 32'h0, q);
      chk("miss_hit", 32'h0, {31'h0, hit});
      base = 32'h0000_5000;
      for (int i = 1; i < 4; i++) begin
         @(negedge clk);
         st[i] = 1'b1;
         rd(12'h008, {28'h0, st});
         chk("mem_hit", 32'h1, {31'h0, hit});
         rd(12'h000, 32'h1 << i);
         wr(12'h000, 32'h0);
         rd(12'h000, 32'h1 << i);
         wr(12'h000, 32'h1 << i);
         rd(12'h000, 32'h0);
      end
      for (int m = 0; m < 2; m++) begin
         cb = m[0];
         for (int e = 0; e < 2; e++) begin
            @(negedge clk);
            st[0] = ~st[0];
            rd(12'h000, {31'h0, ~cb | st[0]});
            wr(12'h000, 32'h1);
         end
      end
      wr(12'h00c, 32'hffff_ffff);
      rd(12'h000, 32'hf);
      for (int a = 12; a <= 32; a += 4) rd(a[11:0], 32'h0);
      crst = 1'b1;
      wr(12'h000, 32'hffff_ffff);
      rd(12'h000, 32'h0);
      crst = 1'b0;
      rd(12'h000, 32'he);
      wr(12'h004, 32'hffff_ffff);
      rd(12'h004, 32'hf);
      for (int k = 0; k < 6; k++) begin
         wr(12'h000, 32'hf);
         wr(12'h004, {28'h0, tab[k][11:8]});
         wr(12'h00c, {28'h0, tab[k][7:4]});
         rd(12'h000, {28'h0, tab[k][7:4]});
         chk("irq", {31'h0, tab[k][0]}, {31'h0, irq});
      end
      wr(12'h000, 32'hf);
      @(negedge clk);
      chk("irq_clear", 32'h0, {31'h0, irq});
      end_of_test();
   end
   initial begin
      #100000;
      n_fail++;
      end_of_test();
   end
endmodule // cardbus_socket_event_mask_tb
`default_nettype wire
